// ---- verilog/rtcac_pkg.sv ----
// Constants, types and register map of the RTC alarm and
// oscillator control block.
// Assumes one 250 MHz clock and an AXI4-Lite register host.
// Summary of operation
// - control bit 2 reads the alarm flag
// - writing bit 2 sets auto reset only
// - alarm flag lasts at most one cycle
// - bit 1 starts set, self clears
// - bit 0 starts capture, self clears
// - oscillator control bit 7 enables gain control
// - bit 6 picks crystal or self oscillate
// - bit 5 enables bias doubling
// - bit 4 reads oscillation valid status
// - oscillator control bits 3:0 read zero
// - configuration bit 7 enables capacitance stepping
// - bit 6 shows capacitance reached target
// - bits 3:0 hold requested load capacitance
// - configuration bits 5:4 read zero
// - pin register bit 7 shorts oscillator pins
// - auto reset zeroes timer after alarm
// - set loads timer, capture copies timer
package rtcac_pkg;

	// ************************************************
	// Register map (word index, byte address = 4 x index)
	// ************************************************
	localparam int         ADDR_W   = 6;
	localparam logic [3:0] IDX_CAP0 = 4'h0; // Capture bytes 0..3
	localparam logic [3:0] IDX_CTL  = 4'h4; // Clock control
	localparam logic [3:0] IDX_XCN  = 4'h5; // Oscillator control
	localparam logic [3:0] IDX_XCF  = 4'h6; // Oscillator config
	localparam logic [3:0] IDX_PIN  = 4'h7; // Pin config
	localparam logic [3:0] IDX_ALM0 = 4'h8; // Alarm bytes 0..3
	localparam logic [3:0] IDX_LAST = 4'hB; // Highest index

	// ************************************************
	// Field positions
	// ************************************************
	localparam int B_ALARM = 2; // Alarm flag / auto reset
	localparam int B_SET   = 1; // Timer load request
	localparam int B_SNAP  = 0; // Timer snapshot request
	localparam int B_GAIN  = 7; // Gain control enable
	localparam int B_MODE  = 6; // Crystal mode select
	localparam int B_BIAS  = 5; // Bias doubling
	localparam int B_STEP  = 7; // Auto capacitance stepping
	localparam int B_SHORT = 7; // Pin short

	// ************************************************
	// Reset values and timing
	// ************************************************
	localparam logic [3:0]  CAP_TGT_RST = 4'h0;
	localparam logic [6:0]  PIN_RSV_RST = 7'h00;
	localparam logic [31:0] WORD_RST    = 32'h0000_0000;
	localparam int          CLK_MHZ     = 250;
	localparam int          STEP_NS     = 1000; // Step interval
	localparam logic [7:0]  STEP_CYC    = 8'(STEP_NS * CLK_MHZ / 1000);
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// Oscillator steering outputs
	typedef struct packed
	{
		logic       gain_en;   // Gain control enable
		logic       mode_xtal; // 1 crystal, 0 self oscillate
		logic       bias2;     // Bias doubling
		logic       pin_short; // Pins shorted
		logic [3:0] load_cap;  // Applied load capacitance
	} rtcac_osc_t;

	// Whole state of the top module
	typedef struct packed
	{
		logic              aw_h;    // Write address held
		logic              w_h;     // Write data held
		logic [ADDR_W-1:0] awa;     // Held write address
		logic [7:0]        wd;      // Held write byte
		logic              ws;      // Held lane 0 strobe
		logic              aw_rdy;
		logic              w_rdy;
		logic              b_v;
		logic [1:0]        bresp;
		logic              ar_rdy;
		logic              r_v;
		logic [7:0]        rd;
		logic [1:0]        rresp;
		logic              auto_rst;
		logic              set_req;
		logic              snap_req;
		logic              alarm_flag;
		logic              gain_en;
		logic              mode_xtal;
		logic              bias2;
		logic              step_en;
		logic [3:0]        cap_tgt;
		logic              pin_short;
		logic [6:0]        pin_rsv;
		logic [31:0]       timer;
		logic [31:0]       capture;
		logic [31:0]       alarm;
		logic [2:0]        vsync;   // Amplitude synchroniser
		logic              vld;
	} rtcac_state_t;

	// Address decode shared by read and write paths
	function automatic logic rtcac_map_ok(input logic [ADDR_W-1:0] a);
		return (a[1:0] == 2'h0) && (a[5:2] <= IDX_LAST);
	endfunction

endpackage

// ---- verilog/rtcac_cap_step.sv ----
// Load capacitance stepper: walks the applied value to the target.
// Assumes target and enable come from the same clock domain.
`timescale 1ns/100ps
module rtcac_cap_step
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       step_en,
	input  wire logic [3:0] cap_tgt,
	output logic      [3:0] cap_now
);
	import rtcac_pkg::*;

	// ************************************************
	// State
	// ************************************************
	typedef struct packed
	{
		logic [7:0] cnt; // Step interval divider
		logic [3:0] cap; // Applied value
	} rtcac_step_t;

	rtcac_step_t s_ff;  // Registered state
	rtcac_step_t nxt_s; // Next state

	// Next state: one step per interval, or jump when disabled
	always_comb
	begin
		nxt_s = s_ff;
		if (s_ff.cnt == STEP_CYC - 8'h01)
			nxt_s.cnt = 8'h00;
		else
			nxt_s.cnt = s_ff.cnt + 8'h01;
		if (!step_en)
			nxt_s.cap = cap_tgt; // Direct load
		else if (s_ff.cnt == STEP_CYC - 8'h01)
		begin
			if (s_ff.cap < cap_tgt)
				nxt_s.cap = s_ff.cap + 4'h1;
			else if (s_ff.cap > cap_tgt)
				nxt_s.cap = s_ff.cap - 4'h1;
		end
	end

	// State register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_ff.cnt <= 8'h00;
			s_ff.cap <= CAP_TGT_RST;
		end
		else
			s_ff <= nxt_s;
	end

	assign cap_now = s_ff.cap;

endmodule

// ---- verilog/rtcac_top.sv ----
// Top of the RTC alarm and oscillator control block: AXI4-Lite
// slave, alarm timer, request bits and oscillator settings.
// Assumes osc_amp_ok arrives asynchronously from the analog cell.
`timescale 1ns/100ps
module rtcac_top
(
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic [rtcac_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                       awvalid,
	output logic                            awready,
	input  wire logic [31:0]                wdata,
	input  wire logic [3:0]                 wstrb,
	input  wire logic                       wvalid,
	output logic                            wready,
	output logic [1:0]                      bresp,
	output logic                            bvalid,
	input  wire logic                       bready,
	input  wire logic [rtcac_pkg::ADDR_W-1:0] araddr,
	input  wire logic                       arvalid,
	output logic                            arready,
	output logic [31:0]                     rdata,
	output logic [1:0]                      rresp,
	output logic                            rvalid,
	input  wire logic                       rready,
	input  wire logic                       osc_amp_ok,
	output logic                            alarm_event,
	output rtcac_pkg::rtcac_osc_t           osc_ctl
);
	import rtcac_pkg::*;

	rtcac_state_t s_ff;    // Registered state
	rtcac_state_t nxt_s;   // Next state
	logic [3:0]   cap_now; // Applied load capacitance
	logic         wr_do;   // Held write commits this cycle
	logic [3:0]   widx;    // Write word index
	logic [3:0]   ridx;    // Read word index
	logic         match;   // Alarm compare event
	logic         cap_rdy; // Capacitance reached target

	// ************************************************
	// Capacitance stepper
	// ************************************************
	rtcac_cap_step u_step
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.step_en (s_ff.step_en),
		.cap_tgt (s_ff.cap_tgt),
		.cap_now (cap_now)
	);

	// ************************************************
	// Next state logic
	// ************************************************
	always_comb
	begin
		nxt_s   = s_ff;
		widx    = s_ff.awa[5:2];
		ridx    = araddr[5:2];
		wr_do   = s_ff.aw_h && s_ff.w_h && !s_ff.b_v;
		match   = (s_ff.timer == s_ff.alarm) && !s_ff.alarm_flag;
		cap_rdy = (cap_now == s_ff.cap_tgt);

		// Amplitude status: three stages, update on agreement
		nxt_s.vsync = {s_ff.vsync[1:0], osc_amp_ok};
		if (s_ff.vsync[1] == s_ff.vsync[2])
			nxt_s.vld = s_ff.vsync[2];

		// Timer runs; alarm flag is a single pulse
		nxt_s.alarm_flag = match;
		nxt_s.timer = s_ff.timer + 32'h1;
		if (match && s_ff.auto_rst)
			nxt_s.timer = WORD_RST;
		if (s_ff.set_req)
		begin
			nxt_s.timer   = s_ff.capture;
			nxt_s.set_req = 1'b0;
		end
		if (s_ff.snap_req)
		begin
			nxt_s.capture  = s_ff.timer;
			nxt_s.snap_req = 1'b0;
		end

		// Address and data channels, taken in either order
		if (awvalid && s_ff.aw_rdy)
		begin
			nxt_s.aw_h = 1'b1;
			nxt_s.awa  = awaddr;
		end
		if (wvalid && s_ff.w_rdy)
		begin
			nxt_s.w_h = 1'b1;
			nxt_s.wd  = wdata[7:0];
			nxt_s.ws  = wstrb[0];
		end

		// Commit a held write; later writes win over clears
		if (wr_do)
		begin
			nxt_s.aw_h  = 1'b0;
			nxt_s.w_h   = 1'b0;
			nxt_s.b_v   = 1'b1;
			nxt_s.bresp = rtcac_map_ok(s_ff.awa) ? RESP_OKAY : RESP_SLVERR;
			if (rtcac_map_ok(s_ff.awa) && s_ff.ws)
			begin
				case (widx)
					IDX_CTL:
					begin
						nxt_s.auto_rst = s_ff.wd[B_ALARM];
						if (s_ff.wd[B_SET])
							nxt_s.set_req = 1'b1;
						if (s_ff.wd[B_SNAP])
							nxt_s.snap_req = 1'b1;
					end
					IDX_XCN:
					begin
						nxt_s.gain_en   = s_ff.wd[B_GAIN];
						nxt_s.mode_xtal = s_ff.wd[B_MODE];
						nxt_s.bias2     = s_ff.wd[B_BIAS];
					end
					IDX_XCF:
					begin
						nxt_s.step_en = s_ff.wd[B_STEP];
						nxt_s.cap_tgt = s_ff.wd[3:0];
					end
					IDX_PIN:
					begin
						nxt_s.pin_short = s_ff.wd[B_SHORT];
						nxt_s.pin_rsv   = s_ff.wd[6:0];
					end
					default:
					begin
						// Capture and alarm bytes, low byte at lowest index
						for (int i = 0; i < 4; i++)
						begin
							if (widx == IDX_CAP0 + 4'(i))
								nxt_s.capture[8*i +: 8] = s_ff.wd;
							if (widx == IDX_ALM0 + 4'(i))
								nxt_s.alarm[8*i +: 8] = s_ff.wd;
						end
					end
				endcase
			end
		end
		if (s_ff.b_v && bready)
			nxt_s.b_v = 1'b0;
		nxt_s.aw_rdy = !nxt_s.aw_h && !nxt_s.b_v;
		nxt_s.w_rdy  = !nxt_s.w_h && !nxt_s.b_v;

		// Read channel: data registered on acceptance
		if (s_ff.r_v && rready)
			nxt_s.r_v = 1'b0;
		if (arvalid && s_ff.ar_rdy)
		begin
			nxt_s.r_v   = 1'b1;
			nxt_s.rresp = rtcac_map_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
			nxt_s.rd    = 8'h00;
			if (rtcac_map_ok(araddr))
			begin
				case (ridx)
					IDX_CTL:
						nxt_s.rd = {5'h00, s_ff.alarm_flag, s_ff.set_req, s_ff.snap_req};
					IDX_XCN:
						nxt_s.rd = {s_ff.gain_en, s_ff.mode_xtal, s_ff.bias2, s_ff.vld, 4'h0};
					IDX_XCF:
						nxt_s.rd = {s_ff.step_en, cap_rdy, 2'h0, s_ff.cap_tgt};
					IDX_PIN:
						nxt_s.rd = {1'b0, s_ff.pin_rsv}; // Short bit is write only
					default:
						nxt_s.rd = ridx[3] ? 8'(s_ff.alarm >> {ridx[1:0], 3'h0})
							: 8'(s_ff.capture >> {ridx[1:0], 3'h0});
				endcase
			end
		end
		nxt_s.ar_rdy = !nxt_s.r_v;
	end

	// ************************************************
	// State register
	// ************************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_ff         <= '0;
			s_ff.cap_tgt <= CAP_TGT_RST;
			s_ff.pin_rsv <= PIN_RSV_RST;
			s_ff.timer   <= WORD_RST;
			s_ff.aw_rdy  <= 1'b1;
			s_ff.w_rdy   <= 1'b1;
			s_ff.ar_rdy  <= 1'b1;
		end
		else
			s_ff <= nxt_s;
	end

	// Outputs straight from state flops
	assign awready           = s_ff.aw_rdy;
	assign wready            = s_ff.w_rdy;
	assign bvalid            = s_ff.b_v;
	assign bresp             = s_ff.bresp;
	assign arready           = s_ff.ar_rdy;
	assign rvalid            = s_ff.r_v;
	assign rresp             = s_ff.rresp;
	assign rdata             = {24'h000000, s_ff.rd};
	assign alarm_event       = s_ff.alarm_flag;
	assign osc_ctl.gain_en   = s_ff.gain_en;
	assign osc_ctl.mode_xtal = s_ff.mode_xtal;
	assign osc_ctl.bias2     = s_ff.bias2;
	assign osc_ctl.pin_short = s_ff.pin_short;
	assign osc_ctl.load_cap  = cap_now;

	// ************************************************
	// Assertions
	// ************************************************
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_rd_flag;
		arvalid && arready && araddr == {IDX_CTL, 2'h0}
			|=> rdata[B_ALARM] == $past(s_ff.alarm_flag);
	endproperty
	a_rd_flag: assert property (p_rd_flag) else $error("flag read wrong");

	property p_autorst_wr;
		// Only a mapped, strobed word may touch a field
		wr_do && s_ff.ws && rtcac_map_ok(s_ff.awa) && widx == IDX_CTL
			|=> s_ff.auto_rst == $past(s_ff.wd[B_ALARM]);
	endproperty
	a_autorst_wr: assert property (p_autorst_wr) else $error("auto reset not written");

	property p_flag_short;
		alarm_event |=> !alarm_event;
	endproperty
	a_flag_short: assert property (p_flag_short) else $error("alarm flag too long");

	property p_set_done;
		s_ff.set_req && !wr_do |=> !s_ff.set_req && s_ff.timer == $past(s_ff.capture);
	endproperty
	a_set_done: assert property (p_set_done) else $error("set not done");

	property p_snap_done;
		s_ff.snap_req && !wr_do |=> !s_ff.snap_req && s_ff.capture == $past(s_ff.timer);
	endproperty
	a_snap_done: assert property (p_snap_done) else $error("capture not done");

	property p_xcn_wr;
		wr_do && s_ff.ws && rtcac_map_ok(s_ff.awa) && widx == IDX_XCN
			|=> {osc_ctl.gain_en, osc_ctl.mode_xtal, osc_ctl.bias2} == $past(s_ff.wd[7:5]);
	endproperty
	a_xcn_wr: assert property (p_xcn_wr) else $error("osc control not written");

	property p_vld_agree;
		// Status may move only after the last two stages agreed
		$changed(s_ff.vld) |-> $past(s_ff.vsync[1]) == $past(s_ff.vsync[2]);
	endproperty
	a_vld_agree: assert property (p_vld_agree) else $error("valid changed early");

	property p_pin_wr;
		wr_do && s_ff.ws && rtcac_map_ok(s_ff.awa) && widx == IDX_PIN
			|=> osc_ctl.pin_short == $past(s_ff.wd[B_SHORT]);
	endproperty
	a_pin_wr: assert property (p_pin_wr) else $error("pin short not written");

	property p_autorst;
		match && s_ff.auto_rst && !s_ff.set_req |=> s_ff.timer == 32'h0 && alarm_event;
	endproperty
	a_autorst: assert property (p_autorst) else $error("timer not reset");

	property p_rdy_drop;
		// Old stepping off, so the applied value cannot land on the new target
		wr_do && s_ff.ws && rtcac_map_ok(s_ff.awa) && widx == IDX_XCF && !s_ff.step_en
			&& s_ff.wd[3:0] != cap_now && s_ff.wd[B_STEP] |=> !cap_rdy;
	endproperty
	a_rdy_drop: assert property (p_rdy_drop) else $error("ready not dropped");

	// Unused fields read back as zero, config fields take the written word
	property p_xcn_low_zero;
		arvalid && arready && araddr == {IDX_XCN, 2'h0} |=> rdata[3:0] == 4'h0;
	endproperty
	a_xcn_low_zero: assert property (p_xcn_low_zero) else $error("osc control low bits not zero");

	property p_xcf_mid_zero;
		arvalid && arready && araddr == {IDX_XCF, 2'h0} |=> rdata[5:4] == 2'h0;
	endproperty
	a_xcf_mid_zero: assert property (p_xcf_mid_zero) else $error("osc config unused bits not zero");

	property p_xcf_wr;
		wr_do && s_ff.ws && rtcac_map_ok(s_ff.awa) && widx == IDX_XCF
			|=> s_ff.cap_tgt == $past(s_ff.wd[3:0]) && s_ff.step_en == $past(s_ff.wd[B_STEP]);
	endproperty
	a_xcf_wr: assert property (p_xcf_wr) else $error("osc config not written");

	c_cap_ready: cover property (s_ff.step_en && $rose(cap_rdy));
	c_write: cover property (bvalid && bready);
	c_read: cover property (rvalid && rready);
	c_alarm: cover property (alarm_event && s_ff.auto_rst);
	c_set: cover property (s_ff.set_req ##1 !s_ff.set_req);

endmodule

// ---- bench/testbench.sv ----
// Self-checking bench for the RTC alarm and oscillator control block.
// Assumes rtcac_pkg and rtcac_top are compiled first; bench acts as bus host.
`timescale 1ns/100ps
module testbench;
	import rtcac_pkg::*;

	// ************************************************
	// Signals
	// ************************************************
	logic              aclk, aresetn;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0]       wdata, rdata;
	logic [3:0]        wstrb;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready;
	logic [1:0]        bresp, rresp;
	logic              osc_amp_ok, alarm_event;
	rtcac_osc_t        osc_ctl;
	int                n_mismatch, samples_checked;

	rtcac_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.osc_amp_ok(osc_amp_ok), .alarm_event(alarm_event), .osc_ctl(osc_ctl));

	// ************************************************
	// Helpers
	// ************************************************
	// Byte address of a word index
	function automatic logic [5:0] ba(input logic [3:0] i);
		return {i, 2'h0};
	endfunction

	// Compare and count
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// Bus write of one byte, response checked
	task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
		int n;
		@(posedge aclk);
		n = 0;
		awaddr <= a;
		wdata <= {24'h000000, d};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1 && n < 50);
		bready <= 1'b0;
		chk({29'h0, bvalid, bresp}, {29'h0, 1'b1, er});
	endtask

	// Bus read, data and response checked
	task automatic rdc(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		@(posedge aclk);
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1 && n < 50);
		rready <= 1'b0;
		chk({29'h0, rvalid, rresp}, {29'h0, 1'b1, er});
		chk(rdata, ed);
	endtask

	// ************************************************
	// Scenarios
	// ************************************************
	// Oscillator control fields, status and unused bits
	task automatic t_osc();
		chk({24'h0, osc_ctl}, 32'h00);
		rdc(ba(IDX_XCN), 32'h00, RESP_OKAY);
		wr(ba(IDX_XCN), 8'hFF, 4'h1, RESP_OKAY);
		rdc(ba(IDX_XCN), 32'hE0, RESP_OKAY);
		chk({24'h0, osc_ctl}, 32'hE0);
		osc_amp_ok <= 1'b1;
		repeat (6) @(posedge aclk);
		rdc(ba(IDX_XCN), 32'hF0, RESP_OKAY);
		wr(ba(IDX_XCN), 8'h40, 4'h1, RESP_OKAY);
		chk({24'h0, osc_ctl}, 32'h40);
		osc_amp_ok <= 1'b0;
		repeat (6) @(posedge aclk);
		rdc(ba(IDX_XCN), 32'h40, RESP_OKAY);
	endtask

	// Capacitance target, stepping and ready flag
	task automatic t_cap();
		wr(ba(IDX_XCF), 8'h3A, 4'h1, RESP_OKAY);
		rdc(ba(IDX_XCF), 32'h4A, RESP_OKAY);
		chk({24'h0, osc_ctl}, 32'h4A);
		wr(ba(IDX_XCF), 8'h85, 4'h1, RESP_OKAY);
		rdc(ba(IDX_XCF), 32'h85, RESP_OKAY);
		repeat (7 * int'(STEP_CYC)) @(posedge aclk);
		rdc(ba(IDX_XCF), 32'hC5, RESP_OKAY);
		chk({24'h0, osc_ctl}, 32'h45);
	endtask

	// Pin short is write only; reserved bits kept by read-modify-write
	task automatic t_pin();
		rdc(ba(IDX_PIN), 32'(PIN_RSV_RST), RESP_OKAY);
		wr(ba(IDX_PIN), {1'b1, PIN_RSV_RST}, 4'h1, RESP_OKAY);
		rdc(ba(IDX_PIN), 32'(PIN_RSV_RST), RESP_OKAY);
		chk({24'h0, osc_ctl}, 32'h55);
		wr(ba(IDX_PIN), {1'b0, PIN_RSV_RST}, 4'h1, RESP_OKAY);
		chk({24'h0, osc_ctl}, 32'h45);
	endtask

	// Timer load then snapshot, byte order and self clearing
	task automatic t_snap();
		wr(ba(IDX_CAP0 + 4'h3), 8'h7F, 4'h1, RESP_OKAY);
		wr(ba(IDX_CTL), 8'h02, 4'h1, RESP_OKAY);
		wr(ba(IDX_CAP0 + 4'h3), 8'h00, 4'h1, RESP_OKAY);
		wr(ba(IDX_CTL), 8'h01, 4'h1, RESP_OKAY);
		rdc(ba(IDX_CAP0 + 4'h3), 32'h7F, RESP_OKAY);
		rdc(ba(IDX_CAP0 + 4'h2), 32'h00, RESP_OKAY);
		rdc(ba(IDX_CTL), 32'h00, RESP_OKAY);
		wr(ba(IDX_CTL), 8'h04, 4'h1, RESP_OKAY);
		rdc(ba(IDX_CTL), 32'h00, RESP_OKAY);
	endtask

	// Auto reset alarm period and one-cycle flag
	task automatic t_alarm();
		int n;
		for (int i = 0; i < 4; i++)
			wr(ba(IDX_CAP0 + 4'(i)), 8'h00, 4'h1, RESP_OKAY);
		wr(ba(IDX_ALM0), 8'h40, 4'h1, RESP_OKAY);
		wr(ba(IDX_CTL), 8'h06, 4'h1, RESP_OKAY);
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (alarm_event !== 1'b1 && n < 200);
		@(posedge aclk);
		chk({31'h0, alarm_event}, 32'h0);
		n = 1;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (alarm_event !== 1'b1 && n < 200);
		chk(n, 32'h41);
		// Next flag stands exactly on the accept edge of this read
		repeat (63) @(posedge aclk);
		rdc(ba(IDX_CTL), 32'h04, RESP_OKAY);
	endtask

	// Unmapped places and a strobe-less write
	task automatic t_bad();
		wr(6'h30, 8'hFF, 4'h1, RESP_SLVERR);
		rdc(6'h30, 32'h00, RESP_SLVERR);
		rdc(6'h15, 32'h00, RESP_SLVERR);
		wr(ba(IDX_XCN), 8'h00, 4'h0, RESP_OKAY);
		rdc(ba(IDX_XCN), 32'h40, RESP_OKAY);
	endtask

	// ************************************************
	// Verdict, clock, watchdog and main sequence
	// ************************************************
	task automatic summarize();
		if (n_mismatch == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	// Cuts a hang short
	initial
	begin
		repeat (20000) @(posedge aclk);
		n_mismatch++;
		summarize();
	end

	initial
	begin
		{aresetn, awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready, osc_amp_ok} = '0;
		n_mismatch = 0;
		samples_checked = 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_osc();
		t_cap();
		t_pin();
		t_snap();
		t_alarm();
		t_bad();
		summarize();
	end
endmodule
